// ---- design/vsb_pkg.sv ----
/*
 * Constants, codes and carrier types of the standard identification,
 * blanking and horizontal loop control block.
 * Assumes a 100 MHz core clock and a 32-bit AXI4-Lite register bus.
 */
package vsb_pkg;
   // ***********************************************
   // Register map
   // ***********************************************
   localparam logic [7:0] OFS_CTRL0 = 8'h00;
   localparam logic [7:0] OFS_CTRL1 = 8'h04;
   localparam logic [7:0] OFS_HELP  = 8'h08;
   localparam logic [7:0] OFS_DLY   = 8'h0c;
   localparam logic [7:0] OFS_STAT0 = 8'h10;
   localparam logic [7:0] OFS_STAT1 = 8'h14;
   localparam logic [7:0] RST_CTRL  = 8'h00;
   localparam int INSEL_LSB = 6;
   localparam int TB_BIT    = 5;
   localparam int COMB_BIT  = 4;
   localparam int FRC_LSB   = 2;
   localparam int XA_BIT    = 1;
   localparam int XB_BIT    = 0;
   localparam int OPEN_BIT  = 4;
   localparam int TCS_LSB   = 2;
   localparam int SAF_BIT   = 1;
   localparam int HOB_BIT   = 5;
   localparam int HBC_BIT   = 4;
   localparam int BSY_BIT   = 3;
   localparam int BPS_BIT   = 7;
   localparam logic [1:0] FRC_SECAM   = 2'h1;
   localparam logic [1:0] FRC_PALNTSC = 2'h2;
   localparam logic [1:0] TCS_FAST    = 2'h0;
   localparam logic [1:0] TCS_SLOW    = 2'h2;
   localparam logic [1:0] INSEL_CVBS  = 2'h0;
   localparam logic [1:0] INSEL_YC    = 2'h1;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ***********************************************
   // Video timing
   // ***********************************************
   localparam logic [9:0] HB50_A_FIRST = 10'd275;
   localparam logic [9:0] HB50_A_LAST  = 10'd371;
   localparam logic [9:0] HB50_B_FIRST = 10'd587;
   localparam logic [9:0] HB50_B_LAST  = 10'd59;
   localparam logic [9:0] HB60_A_FIRST = 10'd230;
   localparam logic [9:0] HB60_A_LAST  = 10'd312;
   localparam logic [9:0] HB60_B_FIRST = 10'd493;
   localparam logic [9:0] HB60_B_LAST  = 10'd49;
   localparam logic [9:0] NOISE_START  = 10'd65;
   localparam logic [9:0] NOISE_LINES  = 10'd15;
   localparam logic [8:0] DIV_MAIN     = 9'd440;
   localparam logic [8:0] DIV_ALT      = 9'd432;
   localparam int DLY_STEP_NS = 40;
   localparam int DLY_W3_NS   = 160;
   localparam int DLY_W2_NS   = 160;
   localparam int DLY_W1_NS   = 80;
   localparam int DLY_W0_NS   = 40;
   localparam logic [1:0] TUNE_443 = 2'h0;
   localparam logic [1:0] TUNE_429 = 2'h1;
   localparam logic [1:0] TUNE_358 = 2'h2;
   // Synchroniser lanes for pin inputs.
   localparam int SY_LINE = 0;
   localparam int SY_VS   = 1;
   localparam int SY_FB   = 2;
   localparam int SY_SINK = 3;
   localparam int SY_ADDR = 4;
   localparam int SY_N    = 5;
   // ***********************************************
   // Types
   // ***********************************************
   typedef enum logic [1:0] {STD_SEARCH, STD_PAL, STD_SECAM, STD_NTSC} vsb_std_type;
   typedef enum logic [1:0] {CAL_POR, CAL_RUN, CAL_DONE} vsb_cal_type;
   typedef enum logic [1:0] {TC_FAST, TC_MED, TC_SLOW} vsb_tc_type;
   typedef struct packed {
      logic field_60hz;
      logic norm_sync_status;
      logic hblank;
      logic vblank;
      logic pal_ok;
      logic secam_line_ok;
      logic ntsc_ok;
      logic auto_yc;
      logic noise_over;
      logic loop_locked;
      logic osc_at_target;
   } vsb_vin_type;
   typedef struct packed {
      logic       notch_bypass;
      logic       yc_input_status;
      logic [1:0] filt_tune;
      logic [3:0] luma_delay_steps;
      logic       dl_bypass;
      logic       comb_dc_high;
      logic       comb_carrier_en;
      logic       secam_cal;
      logic       helper_blank;
      logic       black_fill;
      logic       sync_on_luma;
      logic       crystal_second;
      logic [8:0] div_ratio;
      vsb_tc_type tc;
      logic       loop_open;
      logic       osc_boost;
      logic       cal_active;
   } vsb_vout_type;
endpackage

// ---- design/vsb_top.sv ----
/*
 * Digital control of a multi-standard colour decoder and sync processor:
 * standard search, filter selection, helper and fast blanking, noise
 * detection and horizontal loop control, with AXI4-Lite registers.
 * Assumes line, vertical, fast-blank, comb sink and address pins come
 * from outside the clock domain; vin comes from logic on core_clk.
 */
// Overview of operation
// - Forced standard is SECAM or PAL/NTSC group only; crystal choice set by identified standard.
// - Search skips SECAM unless XA_BIT is set, and standards excluded by forcing.
// - PAL wins over SECAM; SECAM found by line identification only.
// - At 60 Hz with the block bit set, SECAM is never identified.
// - Host reports crystals; single crystal means reference input always.
// - Filters tuned to 4.43, 4.29 or 3.58 MHz by identified standard.
// - Notches bypassed in Y/C mode, or for CVBS when trap bypass set.
// - Luma delay set in 40 ns steps, weights 160, 160, 80, 40 ns.
// - SECAM oscillator recalibrated each vertical blank in search or SECAM.
// - Delay line bypass with gain 2 when set, never in SECAM.
// - Comb pin low without carrier when disabled, high with carrier enabled.
// - Comb enable forces Y/C input and status unless pin sink present.
// - Helper blank off, on, or following noisy flag per two bits.
// - Helper blanking only while norm sync condition is reported.
// - 625-line: blank lines 275 to 371 and 587 through 59.
// - 525-line: blank lines 230 to 312 and 493 through 49.
// - Fast blank flag set when pulses seen in more than one line.
// - Blanked sync substitutes black in blanking; helper extends vertical blank.
// - Line oscillator divided by 440, or 432 for the alternate address.
// - Time constant fast, auto or slow; unlocked auto and slow use medium.
// - Noise sampled 15 lines from line 65; flag after two noisy fields.
// - Oscillator boosted after reset until ctrl1 written after ctrl0.
`timescale 1ns/10ps
module vsb_top
   import vsb_pkg::*;
(
   input  wire logic         core_clk,
   input  wire logic         rst_n,
   input  wire logic [7:0]   s_axi_awaddr,
   input  wire logic         s_axi_awvalid,
   output logic              s_axi_awready,
   input  wire logic [31:0]  s_axi_wdata,
   input  wire logic [3:0]   s_axi_wstrb,
   input  wire logic         s_axi_wvalid,
   output logic              s_axi_wready,
   output logic [1:0]        s_axi_bresp,
   output logic              s_axi_bvalid,
   input  wire logic         s_axi_bready,
   input  wire logic [7:0]   s_axi_araddr,
   input  wire logic         s_axi_arvalid,
   output logic              s_axi_arready,
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   output logic              s_axi_rvalid,
   input  wire logic         s_axi_rready,
   input  wire logic         line_pulse_pin,
   input  wire logic         vertical_pulse_pin,
   input  wire logic         fast_blank_pin,
   input  wire logic         comb_sink_pin,
   input  wire logic         addr_alt_pin,
   input  wire vsb_vin_type  vin,
   output vsb_vout_type      vout
);
   // ***********************************************
   // Helpers
   // ***********************************************
   function automatic logic in_lines(input logic [9:0] n, input logic [9:0] a0, input logic [9:0] a1,
                                     input logic [9:0] b0, input logic [9:0] b1);
      in_lines = (n >= a0 && n <= a1) || n >= b0 || (n >= 10'd1 && n <= b1);
   endfunction

   function automatic logic [3:0] luma_steps(input logic [3:0] yd);
      int ns;
      ns = (yd[3] ? DLY_W3_NS : 0) + (yd[2] ? DLY_W2_NS : 0) + (yd[1] ? DLY_W1_NS : 0) + (yd[0] ? DLY_W0_NS : 0);
      luma_steps = 4'(ns / DLY_STEP_NS);
   endfunction

   // ***********************************************
   // Pin synchronisers
   // ***********************************************
   logic [SY_N-1:0] sy1, sy2, sy3, sy_lvl, next_sy_lvl;
   always_comb begin
      next_sy_lvl = sy_lvl;
      for (int i = 0; i < SY_N; i++) begin
         if (sy2[i] == sy3[i]) begin
            next_sy_lvl[i] = sy3[i];
         end
      end
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sy1    <= '0;
         sy2    <= '0;
         sy3    <= '0;
         sy_lvl <= '0;
      end else begin
         sy1    <= {addr_alt_pin, comb_sink_pin, fast_blank_pin, vertical_pulse_pin, line_pulse_pin};
         sy2    <= sy1;
         sy3    <= sy2;
         sy_lvl <= next_sy_lvl;
      end
   end
   wire logic line_ev  = next_sy_lvl[SY_LINE] & ~sy_lvl[SY_LINE];
   wire logic field_ev = next_sy_lvl[SY_VS] & ~sy_lvl[SY_VS];

   // ***********************************************
   // AXI4-Lite slave and control registers
   // ***********************************************
   logic [7:0] ctrl0, ctrl1, help, dly, next_ctrl0, next_ctrl1, next_help, next_dly;
   logic [7:0] aw_addr, next_aw_addr, w_data, next_w_data;
   logic       w_lane0, next_w_lane0, ctrl0_seen, next_ctrl0_seen, ctrl1_wr, next_ctrl1_wr;
   logic       next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic [7:0] stat0, stat1;
   vsb_std_type std;
   vsb_cal_type cal;
   logic        fba, noisy_signal_flag;

   always_comb begin
      stat0 = {cal == CAL_POR, cal == CAL_RUN, std, vout.yc_input_status, 2'h0, vout.crystal_second};
      stat1 = {3'h0, fba, vin.norm_sync_status, noisy_signal_flag, 2'h0};
      next_ctrl0 = ctrl0;
      next_ctrl1 = ctrl1;
      next_help = help;
      next_dly = dly;
      next_aw_addr = aw_addr;
      next_w_data = w_data;
      next_w_lane0 = w_lane0;
      next_ctrl0_seen = ctrl0_seen;
      next_ctrl1_wr = 1'b0;
      next_awready = s_axi_awready;
      next_wready = s_axi_wready;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      next_arready = s_axi_arready;
      next_rvalid = s_axi_rvalid;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      if (s_axi_awready && s_axi_awvalid) begin
         next_awready = 1'b0;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wready && s_axi_wvalid) begin
         next_wready = 1'b0;
         next_w_data = s_axi_wdata[7:0];
         next_w_lane0 = s_axi_wstrb[0];
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
         next_awready = 1'b1;
         next_wready = 1'b1;
      end else if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
         next_bvalid = 1'b1;
         next_bresp = RESP_OKAY;
         case (aw_addr)
            OFS_CTRL0: begin
               if (w_lane0) begin
                  next_ctrl0 = w_data;
                  next_ctrl0_seen = 1'b1;
               end
            end
            OFS_CTRL1: begin
               if (w_lane0) begin
                  next_ctrl1 = w_data;
                  next_ctrl1_wr = 1'b1;
               end
            end
            OFS_HELP: begin
               if (w_lane0) begin
                  next_help = w_data;
               end
            end
            OFS_DLY: begin
               if (w_lane0) begin
                  next_dly = w_data;
               end
            end
            OFS_STAT0, OFS_STAT1: begin
            end
            default: begin
               next_bresp = RESP_SLVERR;
            end
         endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
         next_arready = 1'b1;
      end else if (s_axi_arready && s_axi_arvalid) begin
         next_arready = 1'b0;
         next_rvalid = 1'b1;
         next_rresp = RESP_OKAY;
         case (s_axi_araddr)
            OFS_CTRL0: next_rdata = {24'h0, ctrl0};
            OFS_CTRL1: next_rdata = {24'h0, ctrl1};
            OFS_HELP:  next_rdata = {24'h0, help};
            OFS_DLY:   next_rdata = {24'h0, dly};
            OFS_STAT0: next_rdata = {24'h0, stat0};
            OFS_STAT1: next_rdata = {24'h0, stat1};
            default: begin
               next_rdata = 32'h0;
               next_rresp = RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl0 <= RST_CTRL;
         ctrl1 <= RST_CTRL;
         help <= RST_CTRL;
         dly <= RST_CTRL;
         aw_addr <= 8'h0;
         w_data <= 8'h0;
         w_lane0 <= 1'b0;
         ctrl0_seen <= 1'b0;
         ctrl1_wr <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         ctrl0 <= next_ctrl0;
         ctrl1 <= next_ctrl1;
         help <= next_help;
         dly <= next_dly;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_lane0 <= next_w_lane0;
         ctrl0_seen <= next_ctrl0_seen;
         ctrl1_wr <= next_ctrl1_wr;
         s_axi_awready <= next_awready;
         s_axi_wready <= next_wready;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_arready <= next_arready;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
      end
   end

   // ***********************************************
   // Video control
   // ***********************************************
   logic [9:0]  line_cnt, next_line_cnt;
   logic [1:0]  fb_lines, next_fb_lines;
   logic [2:0]  strap_cnt, next_strap_cnt;
   logic        fb_seen, next_fb_seen, next_fba, noise_hit, next_noise_hit, prev_hit, next_prev_hit, next_snr;
   logic        addr_alt, next_addr_alt, sec_ok, pn_ok, yc, help_en, hb_range;
   vsb_std_type next_std;
   vsb_cal_type next_cal;
   vsb_vout_type next_vout;

   always_comb begin
      next_line_cnt = line_cnt;
      next_fb_lines = fb_lines;
      next_fb_seen = fb_seen | sy_lvl[SY_FB];
      next_fba = fba;
      next_noise_hit = noise_hit;
      next_prev_hit = prev_hit;
      next_snr = noisy_signal_flag;
      next_std = std;
      next_cal = cal;
      next_addr_alt = addr_alt;
      next_strap_cnt = strap_cnt;
      // The strap is taken until the seventh edge after reset, so the last captures
      // follow the three flops and the agreement stage, which need four edges.
      if (strap_cnt != 3'h7) begin
         next_strap_cnt = strap_cnt + 3'h1;
         next_addr_alt = sy_lvl[SY_ADDR];
      end
      if (line_ev) begin
         next_line_cnt = (line_cnt == 10'h3ff) ? line_cnt : line_cnt + 10'h1;
         next_fb_seen = sy_lvl[SY_FB];
         if (fb_seen && fb_lines != 2'h2) begin
            next_fb_lines = fb_lines + 2'h1;
         end
      end
      if (vin.noise_over && line_cnt >= NOISE_START && line_cnt < NOISE_START + NOISE_LINES) begin
         next_noise_hit = 1'b1;
      end
      sec_ok = ctrl0[XA_BIT] && ctrl0[FRC_LSB+:2] != FRC_PALNTSC
               && !(vin.field_60hz && ctrl1[SAF_BIT]);
      pn_ok = ctrl0[FRC_LSB+:2] != FRC_SECAM;
      if (field_ev) begin
         next_line_cnt = 10'h1;
         // more than one line per field
         next_fba = (fb_lines + {1'b0, fb_seen}) >= 2'h2;
         next_fb_lines = 2'h0;
         next_fb_seen = 1'b0;
         next_prev_hit = noise_hit;
         next_snr = noise_hit ? (prev_hit | noisy_signal_flag) : 1'b0;
         next_noise_hit = 1'b0;
         if (pn_ok && vin.pal_ok) begin
            next_std = STD_PAL;
         // no SECAM at 60 Hz when blocked
         end else if (sec_ok && vin.secam_line_ok) begin
            next_std = STD_SECAM;
         end else if (pn_ok && vin.ntsc_ok) begin
            next_std = STD_NTSC;
         end else begin
            next_std = STD_SEARCH;
         end
      end
      case (cal)
         CAL_POR: begin
            if (ctrl1_wr && ctrl0_seen) begin
               next_cal = CAL_RUN;
            end
         end
         CAL_RUN: begin
            if (vin.osc_at_target) begin
               next_cal = CAL_DONE;
            end
         end
         default: begin
         end
      endcase

      if (ctrl0[COMB_BIT] && !sy_lvl[SY_SINK]) begin
         yc = 1'b1;
      end else if (ctrl0[INSEL_LSB+1]) begin
         yc = vin.auto_yc;
      end else begin
         yc = ctrl0[INSEL_LSB+:2] == INSEL_YC;
      end
      next_vout.yc_input_status = yc;
      next_vout.notch_bypass = yc | ctrl0[TB_BIT];
      next_vout.crystal_second = ctrl0[XB_BIT] && ctrl0[XA_BIT] && std == STD_NTSC;
      if (std == STD_SECAM) begin
         next_vout.filt_tune = TUNE_429;
      end else if (std == STD_NTSC || !ctrl0[XA_BIT]) begin
         next_vout.filt_tune = TUNE_358;
      end else begin
         next_vout.filt_tune = TUNE_443;
      end
      next_vout.luma_delay_steps = luma_steps(dly[3:0]);
      next_vout.dl_bypass = dly[BPS_BIT] && std != STD_SECAM;
      next_vout.comb_dc_high = ctrl0[COMB_BIT];
      next_vout.comb_carrier_en = ctrl0[COMB_BIT];
      next_vout.secam_cal = field_ev && (std == STD_SEARCH || std == STD_SECAM);
      help_en = help[HOB_BIT] && (!help[HBC_BIT] || noisy_signal_flag) && vin.norm_sync_status;
      hb_range = vin.field_60hz ? in_lines(line_cnt, HB60_A_FIRST, HB60_A_LAST, HB60_B_FIRST, HB60_B_LAST)
                                : in_lines(line_cnt, HB50_A_FIRST, HB50_A_LAST, HB50_B_FIRST, HB50_B_LAST);
      next_vout.helper_blank = help_en && hb_range;
      next_vout.sync_on_luma = !help[BSY_BIT];
      next_vout.black_fill = help[BSY_BIT] && (vin.hblank || vin.vblank || (help_en && hb_range));
      next_vout.div_ratio = addr_alt ? DIV_ALT : DIV_MAIN;
      if (ctrl1[TCS_LSB+:2] == TCS_FAST) begin
         next_vout.tc = TC_FAST;
      end else if (!vin.loop_locked) begin
         next_vout.tc = TC_MED;
      end else if (ctrl1[TCS_LSB+:2] == TCS_SLOW || noisy_signal_flag) begin
         next_vout.tc = TC_SLOW;
      end else begin
         next_vout.tc = vin.vblank ? TC_FAST : TC_MED;
      end
      next_vout.loop_open = ctrl1[OPEN_BIT];
      next_vout.osc_boost = next_cal == CAL_POR;
      next_vout.cal_active = next_cal == CAL_RUN;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         line_cnt <= 10'h0;
         fb_lines <= 2'h0;
         fb_seen <= 1'b0;
         fba <= 1'b0;
         noise_hit <= 1'b0;
         prev_hit <= 1'b0;
         noisy_signal_flag <= 1'b0;
         std <= STD_SEARCH;
         cal <= CAL_POR;
         addr_alt <= 1'b0;
         strap_cnt <= 3'h0;
         vout <= '0;
      end else begin
         line_cnt <= next_line_cnt;
         fb_lines <= next_fb_lines;
         fb_seen <= next_fb_seen;
         fba <= next_fba;
         noise_hit <= next_noise_hit;
         prev_hit <= next_prev_hit;
         noisy_signal_flag <= next_snr;
         std <= next_std;
         cal <= next_cal;
         addr_alt <= next_addr_alt;
         strap_cnt <= next_strap_cnt;
         vout <= next_vout;
      end
   end

   // ***********************************************
   // Assertions
   // ***********************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   AST_FORCE_SECAM: assert property (field_ev && ctrl0[FRC_LSB+:2] == FRC_SECAM |=> std != STD_PAL && std != STD_NTSC)
      else $error("forced SECAM yet PAL or NTSC chosen");
   AST_NO_SECAM_60: assert property (field_ev && vin.field_60hz && ctrl1[SAF_BIT] |=> std != STD_SECAM)
      else $error("SECAM identified at 60 Hz while blocked");
   AST_PAL_FIRST: assert property (field_ev && pn_ok && vin.pal_ok |=> std == STD_PAL)
      else $error("PAL lost priority");
   AST_NOTCH: assert property (ctrl0[TB_BIT] |=> vout.notch_bypass)
      else $error("trap bypass ignored");
   AST_BYPASS: assert property (std == STD_SECAM |=> !vout.dl_bypass)
      else $error("delay bypass in SECAM");
   AST_COMB: assert property (!ctrl0[COMB_BIT] && $stable(ctrl0) |=> !vout.comb_dc_high && !vout.comb_carrier_en)
      else $error("comb pin active while disabled");
   AST_SCAL: assert property (field_ev && std == STD_SECAM |=> vout.secam_cal ##1 !vout.secam_cal)
      else $error("SECAM calibration pulse wrong");
   AST_HELP_NORM: assert property (!vin.norm_sync_status |=> !vout.helper_blank)
      else $error("helper blank without norm sync");
   AST_DIV: assert property ($past(rst_n) |-> vout.div_ratio == DIV_MAIN || vout.div_ratio == DIV_ALT)
      else $error("illegal divide ratio");
   AST_TC_UNLOCK: assert property (!vin.loop_locked && ctrl1[TCS_LSB+:2] == TCS_SLOW |=> vout.tc == TC_MED)
      else $error("unlocked loop not medium");
   AST_CAL_HOLD: assert property (cal == CAL_POR && !ctrl0_seen |=> cal == CAL_POR)
      else $error("calibration began before ctrl0 write");
   AST_SNR_TWO: assert property (field_ev && !noise_hit |=> !noisy_signal_flag)
      else $error("noisy flag survives a clean field");

   COV_SECAM: cover property (std == STD_SECAM ##1 std == STD_PAL);
   COV_CAL: cover property (cal == CAL_RUN ##1 cal == CAL_DONE);
   COV_HELP: cover property (vout.helper_blank && vout.black_fill);
   COV_FBA: cover property (field_ev ##1 fba);
endmodule

// ---- dv/video_std_ident_blanking_sync_ctrl_test.sv ----
/* Self-checking bench of vsb_top: AXI4-Lite master, random control words.
   Assumes the video source model drives the timing pins. */
`timescale 1ns/10ps
module video_std_ident_blanking_sync_ctrl_test;
   import vsb_pkg::*;
   logic core_clk = 0, rst_n = 0, link_clk = 0, comb_sink_pin = 0, addr_alt_pin = 0, y;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd, d, seed = 32'h61db85b6;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
   logic line_pulse_pin, vertical_pulse_pin, fast_blank_pin;
   vsb_vin_type vin = '0;
   vsb_vout_type vout;
   int n_fail = 0, tests_run = 0, cyc = 0;
   always #5 core_clk = ~core_clk;
   always #40 link_clk = ~link_clk;
   vsb_top dut (.*);
   vsb_video_src #(.LINES(80)) src (.*);
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] v);
      @(posedge core_clk);
      s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      br = s_axi_bresp; s_axi_bready <= 0;
   endtask
   task automatic rdr(logic [7:0] a);
      @(posedge core_clk);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata; rr = s_axi_rresp; s_axi_rready <= 0;
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // A hang costs a mismatch; the whole run needs under 47000 of the 80000 cycles.
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         n_fail++;
         stop_test();
      end
   end
   initial begin
      repeat (5) @(posedge core_clk);
      rst_n <= 1;
      repeat (6) @(posedge core_clk);
      chk("div_ratio", vout.div_ratio, DIV_MAIN);
      chk("osc_boost", vout.osc_boost, 1);
      rdr(OFS_CTRL0); chk("ctrl0", rd, RST_CTRL);
      rdr(8'h20); chk("rresp", rr, RESP_SLVERR);
      wr(8'h20, 0); chk("bresp", br, RESP_SLVERR);
      wr(OFS_CTRL1, 0); chk("bresp", br, RESP_OKAY);
      repeat (4) @(posedge core_clk);
      chk("cal_early", vout.cal_active, 0);
      wr(OFS_CTRL0, 32'h02); wr(OFS_CTRL1, 0); repeat (4) @(posedge core_clk);
      chk("osc_boost", vout.osc_boost, 0);
      chk("cal_active", vout.cal_active, 1);
      for (int i = 0; i < 8; i++) begin
         d = rnd();
         vin.auto_yc <= d[8];
         wr(OFS_CTRL0, {24'h0, d[7:5], 5'h02}); wr(OFS_DLY, {24'h0, d[20], 3'h0, d[19:16]});
         repeat (4) @(posedge core_clk);
         chk("bypass", vout.dl_bypass, d[20]);
         y = (d[7:6] == INSEL_YC) | (d[7] & d[8]);
         chk("yc_status", vout.yc_input_status, y);
         chk("notch", vout.notch_bypass, y | d[5]);
         chk("delay", vout.luma_delay_steps, 4 * d[19] + 4 * d[18] + 2 * d[17] + d[16]);
      end
      wr(OFS_CTRL0, 32'h12); repeat (8) @(posedge core_clk);
      chk("comb_yc", vout.yc_input_status, 1);
      chk("comb_dc", vout.comb_dc_high, 1);
      comb_sink_pin <= 1; repeat (8) @(posedge core_clk);
      chk("sink_yc", vout.yc_input_status, 0);
      wr(OFS_CTRL0, 32'h02); comb_sink_pin <= 0; repeat (8) @(posedge core_clk);
      chk("comb_off", {vout.comb_dc_high, vout.comb_carrier_en}, 0);
      vin.pal_ok <= 1; vin.secam_line_ok <= 1; vin.loop_locked <= 1;
      repeat (2) @(posedge vertical_pulse_pin);
      repeat (10) @(posedge core_clk);
      rdr(OFS_STAT0); chk("std_pal", rd[5:4], STD_PAL);
      chk("tune", vout.filt_tune, TUNE_443);
      chk("xtal", vout.crystal_second, 0);
      chk("tc_fast", vout.tc, TC_FAST);
      rdr(OFS_STAT1); chk("fba", rd[4], 1);
      wr(OFS_CTRL1, 32'h02); vin.pal_ok <= 0; vin.field_60hz <= 1;
      repeat (2) @(posedge vertical_pulse_pin);
      repeat (10) @(posedge core_clk);
      rdr(OFS_STAT0); chk("std_blk", rd[5:4], STD_SEARCH);
      // Forced SECAM with a PAL burst present: PAL must stay excluded.
      wr(OFS_CTRL0, 32'h06); wr(OFS_DLY, 32'h80); vin.pal_ok <= 1; vin.field_60hz <= 0;
      repeat (2) @(posedge vertical_pulse_pin);
      repeat (10) @(posedge core_clk);
      rdr(OFS_STAT0); chk("std_forced", rd[5:4], STD_SECAM);
      chk("tune_secam", vout.filt_tune, TUNE_429);
      chk("no_bypass", vout.dl_bypass, 0);
      // Noise in the window for three fields, conditional helper blanking on.
      wr(OFS_CTRL1, 32'h04); wr(OFS_HELP, 32'h38); vin.noise_over <= 1; vin.norm_sync_status <= 1;
      repeat (3) @(posedge vertical_pulse_pin);
      repeat (10) @(posedge core_clk);
      rdr(OFS_STAT1); chk("snr", rd[2], 1);
      chk("tc_slow", vout.tc, TC_SLOW);
      chk("help_cond", vout.helper_blank, 1);
      chk("black", {vout.black_fill, vout.sync_on_luma}, 2);
      vin.norm_sync_status <= 0; repeat (3) @(posedge core_clk);
      chk("help_norm", vout.helper_blank, 0);
      // Second reset with the alternate address strap.
      rst_n <= 0; addr_alt_pin <= 1; repeat (5) @(posedge core_clk);
      rst_n <= 1; repeat (10) @(posedge core_clk);
      chk("div_alt", vout.div_ratio, DIV_ALT);
      stop_test();
   end
endmodule

// ---- dv/vsb_video_src.sv ----
/* Video timing source for the bench: line, vertical and fast blank pins.
   Assumes a free-running link clock of 80 ns from the bench. */
`timescale 1ns/10ps
module vsb_video_src #(parameter int LINES = 20) (
   input  wire logic link_clk,
   input  wire logic rst_n,
   output logic      line_pulse_pin,
   output logic      vertical_pulse_pin,
   output logic      fast_blank_pin
);
   int c;
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) c <= 0;
      else c <= (c == 8 * LINES - 1) ? 0 : c + 1;
   end
   assign line_pulse_pin     = rst_n && (c % 8 == 0);
   assign vertical_pulse_pin = rst_n && (c < 4);
   assign fast_blank_pin     = (c >= 16) && (c < 32) && (c % 8 == 4);
endmodule
